// ==== logic/ddl_device.sv ====
// Device end: shift register, command decode and double-buffered latches of both DACs.
`timescale 1ns/10ps
module ddl_device
   import ddl_pkg::*;
#(
   parameter int RES_BITS = 12
)
(
   input wire logic rst_b,
   ddl_if.device link,
   output logic [ddl_pkg::DATA_W-1:0] dac_a_code,
   output logic [ddl_pkg::DATA_W-1:0] dac_b_code
);
   import ddl_pkg::*;

   // Mask that drops the unused low bits of narrower parts.
   localparam logic [DATA_W-1:0] RES_MASK = DATA_W'(((1 << RES_BITS) - 1) << (DATA_W - RES_BITS));

   // Shift-side state, clocked by the serial clock.
   typedef struct packed {
      logic [WORD_W-1:0] shreg;
      logic [CNT_W-1:0] bits;
   } ddl_sh_t;

   // Latch state, clocked by the select rising edge.
   typedef struct packed {
      logic [DATA_W-1:0] in_a;
      logic [DATA_W-1:0] in_b;
      logic [DATA_W-1:0] dac_a;
      logic [DATA_W-1:0] dac_b;
   } ddl_lat_t;

   ddl_sh_t sh_q, sh_d;
   ddl_lat_t lat_q, lat_d;
   logic [CMD_W-1:0] cmd;
   logic [DATA_W-1:0] data;
   logic clear_cnt_b;

   assign cmd = sh_q.shreg[WORD_W-1:CMD_LSB];
   assign data = sh_q.shreg[DATA_W-1:0] & RES_MASK;
   assign dac_a_code = lat_q.dac_a;
   assign dac_b_code = lat_q.dac_b;
   // Counter is cleared asynchronously while select is high, so each frame counts from zero.
   assign clear_cnt_b = rst_b & ~link.select_b;

   // Shift next state; counter saturates so long frames keep the last sixteen bits.
   always_comb begin
      sh_d.shreg = {sh_q.shreg[WORD_W-2:0], link.serial_data_in};
      sh_d.bits = (sh_q.bits == BITS_PER_WORD) ? sh_q.bits : sh_q.bits + 5'h01;
   end

   // Shift register holds data across select high; counter reset gates the clock.
   always_ff @(posedge link.serial_clk or negedge clear_cnt_b) begin
      if (!clear_cnt_b) begin
         sh_q.bits <= '0;
      end else begin
         sh_q <= sh_d;
      end
   end

   // Latch decode; short frames and no-op codes leave everything as it was.
   always_comb begin
      lat_d = lat_q;
      if (sh_q.bits == BITS_PER_WORD) begin
         case (cmd)
            CMD_A_LOAD: lat_d.in_a = data;
            CMD_A_UPD: lat_d.dac_a = lat_q.in_a;
            CMD_A_BOTH: begin
               lat_d.in_a = data;
               lat_d.dac_a = data;
            end
            CMD_B_LOAD: lat_d.in_b = data;
            CMD_B_UPD: lat_d.dac_b = lat_q.in_b;
            CMD_B_BOTH: begin
               lat_d.in_b = data;
               lat_d.dac_b = data;
            end
            CMD_AB_LOAD: begin
               lat_d.in_a = data;
               lat_d.in_b = data;
            end
            CMD_AB_UPD: begin
               lat_d.dac_a = lat_q.in_a;
               lat_d.dac_b = lat_q.in_b;
            end
            CMD_AB_BOTH: begin
               lat_d = '{in_a: data, in_b: data, dac_a: data, dac_b: data};
            end
            default: lat_d = lat_q;
         endcase
      end
   end

   // Select rising edge commits the word; power-on reset clears all latches.
   always_ff @(posedge link.select_b or negedge rst_b) begin
      if (!rst_b) begin
         lat_q <= '{in_a: LATCH_RESET, in_b: LATCH_RESET,
                    dac_a: LATCH_RESET, dac_b: LATCH_RESET};
      end else begin
         lat_q <= lat_d;
      end
   end

   // The shift word needs no reset: decode only looks at it once sixteen bits have filled it.
endmodule

// ==== logic/ddl_pkg.sv ====
// Package with the constants shared by both ends of the dual DAC serial loader.
package ddl_pkg;
   // Word layout.
   localparam int WORD_W = 16;
   localparam int CMD_W = 4;
   localparam int DATA_W = 12;
   localparam int CMD_LSB = 12;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] BITS_PER_WORD = 5'h10;
   localparam logic [DATA_W-1:0] LATCH_RESET = 12'h000;
   // Host clock divider: half period of serial clock in host cycles.
   localparam int HALF_PERIOD = 2;
   // Command codes.
   localparam logic [CMD_W-1:0] CMD_A_LOAD = 4'h0;
   localparam logic [CMD_W-1:0] CMD_A_UPD = 4'h1;
   localparam logic [CMD_W-1:0] CMD_A_BOTH = 4'h2;
   localparam logic [CMD_W-1:0] CMD_B_LOAD = 4'h3;
   localparam logic [CMD_W-1:0] CMD_B_UPD = 4'h4;
   localparam logic [CMD_W-1:0] CMD_B_BOTH = 4'h5;
   localparam logic [CMD_W-1:0] CMD_AB_LOAD = 4'hC;
   localparam logic [CMD_W-1:0] CMD_AB_UPD = 4'hD;
   localparam logic [CMD_W-1:0] CMD_AB_BOTH = 4'hE;
endpackage

// ==== logic/ddl_if.sv ====
// Interface carrying the three serial wires between host and DAC loader.
`timescale 1ns/10ps
interface ddl_if;
   logic serial_clk; // Serial clock, made by the host.
   logic select_b; // Chip select, active low.
   logic serial_data_in; // Serial data, host to device.
   modport host (output serial_clk, output select_b, output serial_data_in);
   modport device (input serial_clk, input select_b, input serial_data_in);
endinterface

// ==== logic/ddl_host.sv ====
// Host end: serialises one command word per request onto the three-wire link.
`timescale 1ns/10ps
module ddl_host
   import ddl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   ddl_if.host link,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [ddl_pkg::CMD_W-1:0] req_cmd,
   input wire logic [ddl_pkg::DATA_W-1:0] req_data
);
   import ddl_pkg::*;

   typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} ddl_hstate_t;

   // All host state in one struct.
   typedef struct packed {
      ddl_hstate_t st;
      logic [WORD_W-1:0] shreg;
      logic [CNT_W-1:0] bits;
      logic [3:0] tick;
      logic sclk;
      logic sel_b;
      logic sdo;
   } ddl_hs_t;

   ddl_hs_t s_q, s_d;

   // Ready only in idle; the serial clock is already low there.
   assign req_ready = (s_q.st == H_IDLE);
   assign link.serial_clk = s_q.sclk;
   assign link.select_b = s_q.sel_b;
   assign link.serial_data_in = s_q.sdo;

   // Next-state logic: divider-paced clock, MSB-first data.
   always_comb begin
      s_d = s_q;
      case (s_q.st)
         H_IDLE: begin
            if (req_valid) begin
               s_d.shreg = {req_cmd, req_data};
               s_d.sdo = req_cmd[CMD_W-1];
               s_d.sel_b = 1'b0;
               s_d.bits = '0;
               s_d.tick = '0;
               s_d.st = H_LOW;
            end
         end
         H_LOW: begin
            // Data set up while clock low; rise after a half period.
            if (s_q.tick == 4'(HALF_PERIOD - 1)) begin
               s_d.tick = '0;
               s_d.sclk = 1'b1;
               s_d.bits = s_q.bits + 5'h01;
               s_d.st = H_HIGH;
            end else begin
               s_d.tick = s_q.tick + 4'h1;
            end
         end
         H_HIGH: begin
            if (s_q.tick == 4'(HALF_PERIOD - 1)) begin
               s_d.tick = '0;
               s_d.sclk = 1'b0;
               s_d.shreg = {s_q.shreg[WORD_W-2:0], 1'b0};
               s_d.sdo = s_q.shreg[WORD_W-2];
               s_d.st = (s_q.bits == BITS_PER_WORD) ? H_END : H_LOW;
            end else begin
               s_d.tick = s_q.tick + 4'h1;
            end
         end
         H_END: begin
            // Clock is low; raising select commits the word.
            if (s_q.tick == 4'(HALF_PERIOD - 1)) begin
               s_d.sel_b = 1'b1;
               s_d.sdo = 1'b0;
               s_d.tick = '0;
               s_d.st = H_IDLE;
            end else begin
               s_d.tick = s_q.tick + 4'h1;
            end
         end
         default: s_d.st = H_IDLE;
      endcase
   end

   // State register; link idles with select high and clock low.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '{st: H_IDLE, shreg: '0, bits: '0, tick: '0, sclk: 1'b0, sel_b: 1'b1, sdo: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ==== bench/ddl_sva.sv ====
// Checker of the serial link between the host and device ends.
`timescale 1ns/10ps
module ddl_sva (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic serial_clk,
   input wire logic select_b,
   input wire logic serial_data_in,
   input wire logic req_ready,
   input wire logic [11:0] dac_a_code,
   input wire logic [11:0] dac_b_code
);
   logic [4:0] rise_q; // Serial clock rises seen in the current frame.
   logic sclk_q; // Serial clock one host cycle ago, for edge finding.
   // Counting on the host clock avoids a third domain in the checker.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rise_q <= 5'h00;
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= serial_clk;
         rise_q <= select_b ? 5'h00 : rise_q + {4'h0, serial_clk & ~sclk_q};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_frame_len; $rose(select_b) |-> rise_q == 5'h10; endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
   property p_dac_hold; !$rose(select_b) |-> $stable(dac_a_code) && $stable(dac_b_code); endproperty
   a_dac_hold: assert property (p_dac_hold) else $error("code moved mid frame");
   property p_idle_clk; select_b |-> !serial_clk; endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("clock runs while idle");
   property p_sel_fall; $fell(select_b) |-> !serial_clk && !$past(serial_clk); endproperty
   a_sel_fall: assert property (p_sel_fall) else $error("select fell with clock high");
   property p_ready; !select_b |-> !req_ready; endproperty
   a_ready: assert property (p_ready) else $error("ready during frame");
   property p_hold; serial_clk && $past(serial_clk) |-> $stable(serial_data_in); endproperty
   a_hold: assert property (p_hold) else $error("data moved with clock high");
   property p_reset; $rose(rst_b) |-> dac_a_code == 12'h000 && dac_b_code == 12'h000; endproperty
   a_reset: assert property (p_reset) else $error("codes not cleared");
   // The host holds the serial clock high for two host cycles, then drops it.
   property p_bit_time; $rose(serial_clk) |-> serial_clk ##1 serial_clk ##1 !serial_clk; endproperty
   a_bit_time: assert property (p_bit_time) else $error("clock high time wrong");
endmodule

// ==== bench/dual_dac_serial_loader_test.sv ====
// Self-checking bench joining the host and device ends over the serial link.
`timescale 1ns/10ps
module dual_dac_serial_loader_test;
   import ddl_pkg::*;
   localparam int RES = 10; // Resolution under test, so the low data bits must drop.
   logic clk, rst_b, req_valid, req_ready;
   logic [CMD_W-1:0] req_cmd;
   logic [DATA_W-1:0] req_data, dac_a_code, dac_b_code;
   logic [WORD_W-1:0] wire_sr; // Word rebuilt from the wire, first bit on top.
   logic [47:0] model; // Expected input A, input B, DAC A, DAC B.
   logic [31:0] r;
   logic [4:0] c;
   int err_total, compares, seed;
   ddl_if link ();
   ddl_host ddl_host_inst (.clk(clk), .rst_b(rst_b), .link(link), .req_valid(req_valid),
      .req_ready(req_ready), .req_cmd(req_cmd), .req_data(req_data));
   ddl_device #(.RES_BITS(RES)) ddl_device_inst (.rst_b(rst_b), .link(link),
      .dac_a_code(dac_a_code), .dac_b_code(dac_b_code));
   ddl_sva ddl_sva_inst (.clk(clk), .rst_b(rst_b), .serial_clk(link.serial_clk),
      .select_b(link.select_b), .serial_data_in(link.serial_data_in),
      .req_ready(req_ready), .dac_a_code(dac_a_code), .dac_b_code(dac_b_code));
   // Free-running host clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Independent capture of the wire, so bit order is judged apart from the device.
   always @(posedge link.serial_clk) if (!link.select_b) wire_sr <= {wire_sr[14:0], link.serial_data_in};
   // Expected latches after one command; update codes copy the old input latch.
   function automatic logic [47:0] step(input logic [47:0] s, input logic [3:0] k,
      input logic [11:0] d);
      logic [11:0] ia, ib, da, db, m;
      {ia, ib, da, db} = s;
      m = d & (12'hFFF << (12 - RES));
      if (k inside {4'h0, 4'h2, 4'hC, 4'hE}) ia = m;
      if (k inside {4'h3, 4'h5, 4'hC, 4'hE}) ib = m;
      if (k inside {4'h1, 4'h2, 4'hD, 4'hE}) da = ia;
      if (k inside {4'h4, 4'h5, 4'hD, 4'hE}) db = ib;
      return {ia, ib, da, db};
   endfunction
   // Compares one value and counts it.
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Sends one word and waits, with a bound, for the host to go idle again.
   task automatic send(input logic [3:0] k, input logic [11:0] d);
      int n;
      @(posedge clk);
      req_valid <= 1'b1;
      req_cmd <= k;
      req_data <= d;
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (!req_ready && n < 200);
      if (!req_ready) begin
         err_total++;
         report_and_stop();
      end
      model = step(model, k, d);
      check("wire word", wire_sr, {k, d});
      check("dac a", {4'h0, dac_a_code}, {4'h0, model[23:12]});
      check("dac b", {4'h0, dac_b_code}, {4'h0, model[11:0]});
      $display("test done cmd %h data %h", k, d);
   endtask
   // Main sequence: reset, a hand-made update corner, every code, then random words.
   initial begin
      seed = 32'h26d5;
      err_total = 0;
      compares = 0;
      model = '0;
      wire_sr = '0;
      rst_b = 1'b0;
      req_valid = 1'b0;
      req_cmd = 4'h0;
      req_data = 12'h000;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      #1;
      check("reset a", {4'h0, dac_a_code}, 16'h0000);
      check("reset b", {4'h0, dac_b_code}, 16'h0000);
      send(4'h0, 12'hABC);
      send(4'h1, 12'h123);
      for (c = 5'h00; c < 5'h10; c++) begin
         r = $random(seed);
         send(c[3:0], r[11:0]);
      end
      repeat (40) begin
         r = $random(seed);
         send(r[15:12], r[11:0]);
      end
      report_and_stop();
   end
endmodule
